// ### rtl/fsk_cfg.svh
// timing and tap constants for the two-tone data encoder
`ifndef FSK_CFG_SVH
`define FSK_CFG_SVH

// system clock and crystal reference, in Hz
`define FSK_CLK_HZ 64'd50000000
`define FSK_REF_HZ 64'd3686400

// reference to master clock ratio
`define FSK_REF_DIV 3'd6
`define FSK_REF_LAST 3'd5

// master clock figure, in Hz (reference over six)
`define FSK_MASTER_HZ 614400

// phase accumulator width and its step for the reference tick
`define FSK_ACC_W 32
`define FSK_ACC_STEP ((`FSK_REF_HZ << 32) / `FSK_CLK_HZ)

// tone divider: 614.4 kHz / 512 = 1200 Hz, / 256 = 2400 Hz
`define FSK_TONE_W 9
`define FSK_TAP_1200 8
`define FSK_TAP_2400 7

// test wave divider: / 16384 = 37.5 Hz, / 262144 = about 2.3 Hz
`define FSK_WAVE_W 18
`define FSK_TAP_PHASE 13
`define FSK_TAP_BLINK 17

// output buffer depth
`define FSK_BUF_DEPTH 2

`endif

// ### rtl/fsk_pkg.sv
// types shared by the two-tone data encoder
package fsk_pkg;

  // where the bit entering the synchroniser comes from
  typedef enum logic [1:0] {
    SRC_CONTROLLER,
    SRC_FAILSOFT,
    SRC_PHASE_WAVE,
    SRC_LEVEL_TONE
  } src_type;

endpackage

// ### rtl/fsk_data_encoder.sv
// two-tone (FSK) encoder for low-speed controller data with test modes
`timescale 1ns/1ns
`include "fsk_cfg.svh"

module fsk_data_encoder (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // front panel switch and jumpers
  input wire logic mode_switch,
  input wire logic test_select_jumper,
  input wire logic tone_select_jumper,
  // data sources
  input wire logic controller_data,
  input wire logic failsoft_word,
  input wire logic failsoft_active,
  // encoded tone stream toward the line
  output logic fsk_valid,
  output logic fsk_data,
  input wire logic fsk_ready,
  // indicators and monitor
  output logic power_led,
  output logic monitor_jack,
  output fsk_pkg::src_type src_mode
);
  import fsk_pkg::*;

  // ------------------------------------------------------------
  // source selection
  // ------------------------------------------------------------
  localparam logic [`FSK_ACC_W-1:0] ACC_STEP =
    `FSK_ACC_W'(`FSK_ACC_STEP);

  logic [`FSK_ACC_W-1:0] acc_q;
  logic [`FSK_ACC_W:0] acc_sum;
  logic ref_tick;
  logic [2:0] ref_cnt_q;
  logic master_tick;
  logic pend_q;
  logic step;
  logic buf_in_ready;

  logic [`FSK_WAVE_W-1:0] wave_q;
  logic [`FSK_TONE_W-1:0] tone_q;
  logic sync1_q;
  logic sync2_q;
  logic restart;
  logic src_bit;
  logic tone_bit;
  src_type src_d;

  logic mon_q;
  logic led_q;
  src_type mode_q;

  logic [`FSK_BUF_DEPTH-1:0] mem_q;
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] count_q;
  logic push;
  logic pop;

  // decode of the panel controls into a source
  function automatic src_type pick_source(
    input logic test_mode,
    input logic phase_sel,
    input logic in_failsoft
  );
    src_type s;
    if (test_mode) begin
      s = phase_sel ? SRC_PHASE_WAVE : SRC_LEVEL_TONE;
    end else begin
      s = in_failsoft ? SRC_FAILSOFT : SRC_CONTROLLER;
    end
    return s;
  endfunction

  assign src_d = pick_source(mode_switch, test_select_jumper,
                             failsoft_active);

  always_comb begin
    unique case (src_d)
      SRC_CONTROLLER: src_bit = controller_data;
      SRC_FAILSOFT: src_bit = failsoft_word;
      SRC_PHASE_WAVE: src_bit = wave_q[`FSK_TAP_PHASE];
      SRC_LEVEL_TONE: src_bit = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // master clock tick
  // ------------------------------------------------------------
  // a phase accumulator stands in for the crystal reference, so the
  // average rate is right to within the truncation of ACC_STEP even though 50 MHz is no integer multiple
  assign acc_sum = {1'b0, acc_q} + {1'b0, ACC_STEP};
  assign ref_tick = acc_sum[`FSK_ACC_W];
  assign master_tick = ref_tick && (ref_cnt_q == `FSK_REF_LAST);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acc_q <= '0;
    end else begin
      acc_q <= acc_sum[`FSK_ACC_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ref_cnt_q <= 3'h0;
    end else if (ref_tick) begin
      if (ref_cnt_q == `FSK_REF_LAST) begin
        ref_cnt_q <= 3'h0;
      end else begin
        ref_cnt_q <= ref_cnt_q + 3'h1;
      end
    end
  end

  // a tick that meets a full buffer waits here; the wave divider, synchroniser,
  // tone divider and buffer stall with it so no tone sample is dropped
  assign step = (master_tick || pend_q) && buf_in_ready;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pend_q <= 1'b0;
    end else if (step) begin
      pend_q <= 1'b0;
    end else if (master_tick) begin
      pend_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // test wave and blink divider
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wave_q <= '0;
    end else if (step) begin
      wave_q <= wave_q + `FSK_WAVE_W'(1);
    end
  end

  // ------------------------------------------------------------
  // data synchroniser
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else if (step) begin
      sync1_q <= src_bit;
      sync2_q <= sync1_q;
    end
  end

  // ------------------------------------------------------------
  // tone divider
  // ------------------------------------------------------------
  // restarting on a data edge puts every transition at a zero
  // crossing of whichever tone follows it
  assign restart = sync1_q ^ sync2_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tone_q <= '0;
    end else if (step) begin
      if (restart) begin
        tone_q <= '0;
      end else begin
        tone_q <= tone_q + `FSK_TONE_W'(1);
      end
    end
  end

  always_comb begin
    if (src_d == SRC_LEVEL_TONE) begin
      tone_bit = tone_select_jumper ? tone_q[`FSK_TAP_1200]
                                    : tone_q[`FSK_TAP_2400];
    end else begin
      tone_bit = sync2_q ? tone_q[`FSK_TAP_1200]
                         : tone_q[`FSK_TAP_2400];
    end
  end

  // ------------------------------------------------------------
  // output buffer
  // ------------------------------------------------------------
  assign push = step;
  assign pop = fsk_valid && fsk_ready;
  assign buf_in_ready = (count_q != 2'(`FSK_BUF_DEPTH));
  assign fsk_valid = (count_q != 2'h0);
  assign fsk_data = mem_q[rd_ptr_q];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mem_q <= '0;
    end else if (push) begin
      mem_q[wr_ptr_q] <= tone_bit;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count_q <= 2'h0;
    end else if (push && !pop) begin
      count_q <= count_q + 2'h1;
    end else if (pop && !push) begin
      count_q <= count_q - 2'h1;
    end
  end

  // ------------------------------------------------------------
  // indicators and monitor
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mon_q <= 1'b0;
    end else begin
      mon_q <= src_bit;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      led_q <= 1'b1;
    end else if (mode_switch) begin
      led_q <= wave_q[`FSK_TAP_BLINK];
    end else begin
      led_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_q <= SRC_CONTROLLER;
    end else begin
      mode_q <= src_d;
    end
  end

  assign monitor_jack = mon_q;
  assign power_led = led_q;
  assign src_mode = mode_q;

endmodule

// ### verif/fsk_enc_chk.sv
// port assertions for the two-tone encoder
`timescale 1ns/1ns
module fsk_enc_chk (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // controls
  input wire logic mode_switch,
  input wire logic test_select_jumper,
  input wire logic controller_data,
  input wire logic failsoft_word,
  input wire logic failsoft_active,
  input wire logic fsk_ready,
  // outputs
  input wire logic fsk_valid,
  input wire logic fsk_data,
  input wire logic power_led,
  input wire logic monitor_jack,
  input fsk_pkg::src_type src_mode
);
  import fsk_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // one master tick is about 81.4 clocks
  sequence s_refill;
    ##[1:90] fsk_valid;
  endsequence
  property p_led; !mode_switch |=> power_led; endproperty
  a_led: assert property (p_led) else $error("led dark");
  property p_ctl;
    !mode_switch && !failsoft_active |=> src_mode == SRC_CONTROLLER;
  endproperty
  a_ctl: assert property (p_ctl) else $error("bad source");
  property p_fs;
    !mode_switch && failsoft_active |=> src_mode == SRC_FAILSOFT;
  endproperty
  a_fs: assert property (p_fs) else $error("bad source");
  property p_ph;
    mode_switch && test_select_jumper |=> src_mode == SRC_PHASE_WAVE;
  endproperty
  a_ph: assert property (p_ph) else $error("bad source");
  property p_lvl;
    mode_switch && !test_select_jumper
      |=> src_mode == SRC_LEVEL_TONE && !monitor_jack;
  endproperty
  a_lvl: assert property (p_lvl) else $error("bad level");
  property p_mc;
    !mode_switch && !failsoft_active
      |=> monitor_jack == $past(controller_data);
  endproperty
  a_mc: assert property (p_mc) else $error("bad monitor");
  property p_mf;
    !mode_switch && failsoft_active |=> monitor_jack == $past(failsoft_word);
  endproperty
  a_mf: assert property (p_mf) else $error("bad monitor");
  property p_hold;
    fsk_valid && !fsk_ready |=> fsk_valid && $stable(fsk_data);
  endproperty
  a_hold: assert property (p_hold) else $error("sample lost");
  property p_refill; $fell(fsk_valid) |-> s_refill; endproperty
  a_refill: assert property (p_refill) else $error("slow tick");
endmodule
bind fsk_data_encoder fsk_enc_chk i_chk (.clk, .sys_rst, .mode_switch,
  .test_select_jumper, .controller_data, .failsoft_word, .failsoft_active,
  .fsk_ready, .fsk_valid, .fsk_data, .power_led, .monitor_jack, .src_mode);

// ### verif/fsk_line_sink.sv
// line side sink with random back-pressure
`timescale 1ns/1ns
module fsk_line_sink (
  // clock
  input wire logic clk,
  // stream
  input wire logic fsk_valid,
  output logic fsk_ready = 1'b0,
  // long hold-off from the bench
  input wire logic stall
);
  logic [15:0] lfsr_q = 16'hACE1;
  always @(negedge clk) begin
    lfsr_q <= {lfsr_q[14:0],
               lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    fsk_ready <= !stall && lfsr_q[0];
  end
endmodule

// ### verif/test_fsk_data_encoder.sv
// self-checking bench for the two-tone encoder
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] %0t %h %h", $time, a, b); end end
module test_fsk_data_encoder;
  import fsk_pkg::*;
  logic clk, sys_rst, mode_switch, test_select_jumper, tone_select_jumper;
  logic controller_data, failsoft_word, failsoft_active, stall;
  logic fsk_valid, fsk_data, fsk_ready, power_led, monitor_jack, last_q = 0;
  src_type src_mode;
  logic [31:0] seed_q = 32'h52CE;
  int n_fail, total_checks, cyc, pops, rises, falls, run, ones;
  fsk_data_encoder i_dut (.clk, .sys_rst, .mode_switch, .test_select_jumper,
    .tone_select_jumper, .controller_data, .failsoft_word, .failsoft_active,
    .fsk_valid, .fsk_data, .fsk_ready, .power_led, .monitor_jack, .src_mode);
  fsk_line_sink i_sink (.clk, .fsk_valid, .fsk_ready, .stall);
  // ----
  // helpers
  // ----
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  // samples in one half period of the tone
  function automatic int half(input logic one);
    return 614400 / (one ? 1200 : 2400) / 2;
  endfunction
  task wrap_up;
    if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task rst;
    sys_rst = 1;
    repeat (8) @(negedge clk);
    sys_rst = 0;
  endtask
  // skip past any restart, then time one full high half period
  task tone_chk(input int exp);
    int r;
    r = pops + 6;
    while (pops < r) @(negedge clk);
    r = rises;
    while (rises == r) @(negedge clk);
    r = falls;
    while (falls == r) @(negedge clk);
    `CHK(ones, exp)
  endtask
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    // scenarios need about 85k clocks at one sample per 81.4 clocks
    if (cyc == 95000) begin
      n_fail++;
      wrap_up();
    end
  end
  always @(posedge clk) if (fsk_valid === 1'b1 && fsk_ready) begin
    pops++;
    if (fsk_data !== last_q) begin
      if (last_q) falls++;
      else rises++;
      if (last_q) ones = run;
      run = 0;
    end
    run++;
    last_q = fsk_data;
  end
  // ----
  // main sequence
  // ----
  initial begin
    {mode_switch, test_select_jumper, tone_select_jumper} = 0;
    {controller_data, failsoft_word, failsoft_active, stall} = 0;
    rst();
    `CHK(power_led, 1'b1)
    `CHK(src_mode, SRC_CONTROLLER)
    repeat (600) begin
      @(negedge clk);
      seed_q = xs(seed_q);
      {mode_switch, test_select_jumper, tone_select_jumper, controller_data,
        failsoft_word, failsoft_active} = seed_q[5:0];
      stall = seed_q[9] & seed_q[8];
    end
    {mode_switch, controller_data, failsoft_word, stall} = 0;
    failsoft_active = 1;
    rst();
    tone_chk(half(0));
    failsoft_active = 0;
    controller_data = 1;
    stall = 1;
    repeat (400) @(negedge clk);
    stall = 0;
    tone_chk(half(1));
    // 2400 Hz level tone keeps the run inside the cycle budget
    {mode_switch, test_select_jumper, tone_select_jumper} = 3'b100;
    tone_chk(half(0));
    wrap_up();
  end
endmodule
